// [src/tbi_cfg.svh]
// constants for the translation cache tag and invalidation filter
// assumes inclusion by bare name from the package and the design module
`ifndef TBI_CFG_SVH
`define TBI_CFG_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TBI_OFF_CAPS        12'h000
`define TBI_OFF_CTRL        12'h004
`define TBI_OFF_DONE_CNT    12'h008
`define TBI_OFF_DROP_CNT    12'h00c
`define TBI_OFF_OCCUPANCY   12'h010

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TBI_CAPS_BCAST_BIT  0
`define TBI_CAPS_S2_BIT     1
`define TBI_CAPS_WIDE_BIT   2
`define TBI_CAPS_SEC_BIT    3
`define TBI_CTRL_IGN_NS_BIT 0
`define TBI_CTRL_IGN_S_BIT  1
`define TBI_CTRL_DOM_LSB    2
`define TBI_CTRL_DOM_MSB    3

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define TBI_CTRL_RESET      4'h0
`define TBI_NARROW_VMT_W    8
`define TBI_TAG_W           16

`endif

// [src/tbi_pkg.sv]
// types shared by the translation cache tag and invalidation filter
// assumes the constants header is on the include path
package tbi_pkg;

`include "tbi_cfg.svh"

	typedef enum logic [2:0] {
		REG_NS_KERNEL,
		REG_SECURE_KERNEL,
		REG_HYP,
		REG_HYP_HOST,
		REG_MONITOR
	} tbi_regime_type;

	typedef enum logic [2:0] {
		OP_BY_ADDRESS,
		OP_BY_ADDRESS_ALL_TAGS,
		OP_BY_SPACE_TAG,
		OP_ALL_IN_REGIME,
		OP_HYP_INVALIDATE_ALL,
		OP_STAGE2_BY_ADDRESS
	} tbi_op_type;

	typedef struct packed {
		logic                     valid;
		tbi_regime_type           regime;
		logic                     stage2;
		logic                     global;
		logic                     shared_set_flag;
		logic [`TBI_TAG_W-1:0]    address_space_tag;
		logic [`TBI_TAG_W-1:0]    virtual_machine_tag;
		logic [35:0]              page;
	} tbi_entry_type;

	typedef struct packed {
		tbi_regime_type           regime;
		logic                     stage2;
		logic                     global;
		logic                     shared_set_flag;
		logic [`TBI_TAG_W-1:0]    address_space_tag;
		logic [`TBI_TAG_W-1:0]    stage2_vm_tag_field;
		logic [35:0]              page;
	} tbi_insert_type;

	typedef struct packed {
		tbi_regime_type           regime;
		logic                     shared_set_flag;
		logic [`TBI_TAG_W-1:0]    address_space_tag;
		logic [`TBI_TAG_W-1:0]    virtual_machine_tag;
		logic [35:0]              page;
	} tbi_lookup_type;

	typedef struct packed {
		tbi_op_type               op;
		tbi_regime_type           regime;
		logic                     scope_stage1;
		logic                     scope_stage2;
		logic [`TBI_TAG_W-1:0]    address_space_tag;
		logic [`TBI_TAG_W-1:0]    virtual_machine_tag;
		logic [35:0]              page;
	} tbi_inval_type;

	typedef struct packed {
		tbi_inval_type            inv;
		logic [1:0]               domain;
		logic                     secure;
		logic                     from_no_hyp;
	} tbi_bcast_type;

endpackage : tbi_pkg

// [src/tbi_tag_filter.sv]
// translation cache tag store with broadcast and command invalidation filtering
// assumes an apb master on pclk, a walker that inserts entries and a command queue
// that presents decoded invalidations; broadcasts arrive already on pclk
//
// What this block does
// - each entry carries regime, address space tag and vm tag as regime allows
// - vm tag is sixteen bits wide when stage 2 and wide tags are present
// - every nonsecure kernel entry carries a vm tag when stage 2 exists
// - the stored vm tag comes from the stage-2 tag field of the stream entry
// - without stage 2 no vm tag is kept in entries
// - a read-only capability bit reports broadcast invalidation support
// - each broadcast is decoded into address, tags, stage scope and regime
// - broadcasts act only when their domain matches the assigned domain
// - ignore control per security state discards all its broadcasts
// - unimplemented stage or security state is dropped, implemented stages still act
// - without stage 2, vm-using broadcasts match as vm tag zero
// - with stage 2, broadcasts from cores lacking hypervisor use vm tag zero
// - non-shared kernel and host-mode entries skip broadcast by-address and by-space-tag, others remove them
// - shared entries are removed by every matching broadcast
// - the set flag never shields stage 2 information
// - non-global lookups and commands ignore the set flag
// - the set flag takes part in global entry lookups
// - global entries hit only same regime and same set flag
// - hypervisor and monitor stage 1 entries ignore the address space tag
// - non-shared hypervisor entries survive by-address ops, not hypervisor invalidate-all
// - non-shared monitor entries survive by-address, not hypervisor invalidate-all
// - host-mode broadcasts need not hit plain hypervisor entries
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

`include "tbi_cfg.svh"

module tbi_tag_filter #(
	parameter int ENTRIES         = 8,
	parameter bit STAGE2_PRESENT  = 1'b1,
	parameter bit WIDE_VM_TAG     = 1'b1,
	parameter bit BCAST_SUPPORTED = 1'b1,
	parameter bit SECURE_PRESENT  = 1'b1
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    ins_valid,
	input  wire tbi_pkg::tbi_insert_type ins_data,
	input  wire logic                    lk_valid,
	input  wire tbi_pkg::tbi_lookup_type lk_data,
	output logic                         lk_done,
	output logic                         lk_hit,
	output logic [7:0]                   lk_index,
	input  wire logic                    cmd_valid,
	input  wire tbi_pkg::tbi_inval_type  cmd_data,
	output logic                         cmd_ready,
	input  wire logic                    bc_valid,
	input  wire tbi_pkg::tbi_bcast_type  bc_data,
	output logic                         bc_ready
);
	import tbi_pkg::*;

	localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tbi_entry_type       ent_r [ENTRIES];
	logic [IW-1:0]       victim_r;
	logic [3:0]          ctrl_r;
	logic [15:0]         done_cnt_r;
	logic [15:0]         drop_cnt_r;
	logic [31:0]         prdata_r;
	logic                pslverr_r;
	logic                lk_done_r;
	logic                lk_hit_r;
	logic [7:0]          lk_index_r;

	// ------------------------------------------------------------
	// tag helpers
	// ------------------------------------------------------------
	function automatic logic uses_vm(input tbi_regime_type rg);
		uses_vm = STAGE2_PRESENT && (rg == REG_NS_KERNEL || rg == REG_SECURE_KERNEL);
	endfunction : uses_vm

	function automatic logic has_space_tag(input tbi_regime_type rg);
		// hypervisor and monitor stage 1 carry no address space tag
		has_space_tag = (rg == REG_NS_KERNEL || rg == REG_SECURE_KERNEL || rg == REG_HYP_HOST);
	endfunction : has_space_tag

	function automatic logic [`TBI_TAG_W-1:0] vm_width(input logic [`TBI_TAG_W-1:0] t);
		// narrow parts keep only the low byte so upper bits never alias
		vm_width = WIDE_VM_TAG ? t : {{(`TBI_TAG_W-`TBI_NARROW_VMT_W){1'b0}}, t[`TBI_NARROW_VMT_W-1:0]};
	endfunction : vm_width

	// one comparator used by both invalidation sources
	function automatic logic inval_hit(input tbi_entry_type e, input tbi_inval_type q, input logic from_bcast);
		logic stage_ok;
		logic vm_ok;
		logic tag_ok;
		logic shield;
		stage_ok = e.stage2 ? q.scope_stage2 : q.scope_stage1;
		vm_ok    = !uses_vm(e.regime) || (e.virtual_machine_tag == q.virtual_machine_tag);
		tag_ok   = 1'b0;
		case (q.op)
			OP_BY_ADDRESS:          tag_ok = !e.stage2 && e.page == q.page &&
			                                 (e.global || !has_space_tag(e.regime) ||
			                                  e.address_space_tag == q.address_space_tag);
			OP_BY_ADDRESS_ALL_TAGS: tag_ok = !e.stage2 && e.page == q.page;
			OP_BY_SPACE_TAG:        tag_ok = !e.stage2 && !e.global && has_space_tag(e.regime) &&
			                                 e.address_space_tag == q.address_space_tag;
			OP_ALL_IN_REGIME:       tag_ok = 1'b1;
			OP_HYP_INVALIDATE_ALL:  tag_ok = 1'b1;
			OP_STAGE2_BY_ADDRESS:   tag_ok = e.stage2 && e.page == q.page;
			default:                tag_ok = 1'b0;
		endcase
		// non-shared stage 1 entries may opt out of address-keyed and space-tag broadcasts
		shield = 1'b0;
		if (from_bcast && e.shared_set_flag && !e.stage2) begin
			case (e.regime)
				REG_HYP:     shield = (q.op == OP_BY_ADDRESS) || (q.op == OP_BY_ADDRESS_ALL_TAGS);
				REG_MONITOR: shield = (q.op == OP_BY_ADDRESS);
				default:     shield = (q.op == OP_BY_ADDRESS) || (q.op == OP_BY_SPACE_TAG);
			endcase
		end
		// host-mode requests never name the plain hypervisor regime, so exact compare suffices
		inval_hit = e.valid && e.regime == q.regime && stage_ok && vm_ok && tag_ok && !shield;
	endfunction : inval_hit

	function automatic logic lookup_hit(input tbi_entry_type e, input tbi_lookup_type q);
		logic tag_ok;
		if (e.global)
			tag_ok = e.shared_set_flag == q.shared_set_flag;
		else
			tag_ok = !has_space_tag(e.regime) || e.address_space_tag == q.address_space_tag;
		lookup_hit = e.valid && !e.stage2 && e.regime == q.regime && e.page == q.page && tag_ok &&
		             (!uses_vm(e.regime) || e.virtual_machine_tag == vm_width(q.virtual_machine_tag));
	endfunction : lookup_hit

	// ------------------------------------------------------------
	// broadcast decode
	// ------------------------------------------------------------
	tbi_inval_type bc_inv;
	logic          bc_accept;
	logic          sec_regime;

	always_comb begin
		bc_inv     = bc_data.inv;
		sec_regime = bc_data.secure;
		// a missing stage is removed from the scope rather than dropping the whole message
		bc_inv.scope_stage2 = bc_data.inv.scope_stage2 && STAGE2_PRESENT;
		if (uses_vm(bc_data.inv.regime) && bc_data.from_no_hyp)
			bc_inv.virtual_machine_tag = '0;
		else if (!STAGE2_PRESENT)
			bc_inv.virtual_machine_tag = '0;
		else
			bc_inv.virtual_machine_tag = vm_width(bc_data.inv.virtual_machine_tag);
		// a dropped broadcast still completes its handshake so the core never stalls
		bc_accept = BCAST_SUPPORTED &&
		            bc_data.domain == ctrl_r[`TBI_CTRL_DOM_MSB:`TBI_CTRL_DOM_LSB] &&
		            !(sec_regime ? ctrl_r[`TBI_CTRL_IGN_S_BIT] : ctrl_r[`TBI_CTRL_IGN_NS_BIT]) &&
		            (SECURE_PRESENT || !sec_regime) &&
		            (bc_inv.scope_stage1 || bc_inv.scope_stage2);
	end

	// ------------------------------------------------------------
	// shared invalidation datapath
	// ------------------------------------------------------------
	tbi_inval_type       cmd_inv;
	tbi_inval_type       sel_inv;
	logic                sel_bcast;
	logic                sel_go;
	logic [ENTRIES-1:0]  kill;

	// commands take priority; broadcasts wait for every cycle that cmd_valid is high
	assign cmd_ready = 1'b1;
	assign bc_ready  = !cmd_valid;

	// commands see the same vm tag width as broadcasts, or narrow parts would miss
	always_comb begin
		cmd_inv                     = cmd_data;
		cmd_inv.virtual_machine_tag = vm_width(cmd_data.virtual_machine_tag);
	end

	always_comb begin
		sel_bcast = !cmd_valid;
		sel_inv   = cmd_valid ? cmd_inv : bc_inv;
		sel_go    = cmd_valid || (bc_valid && bc_accept);
		for (int i = 0; i < ENTRIES; i++)
			kill[i] = sel_go && inval_hit(ent_r[i], sel_inv, sel_bcast);
	end

	// ------------------------------------------------------------
	// insertion tagging
	// ------------------------------------------------------------
	tbi_entry_type new_ent;

	always_comb begin
		new_ent.valid           = 1'b1;
		new_ent.regime          = ins_data.regime;
		new_ent.stage2          = ins_data.stage2;
		new_ent.global          = ins_data.global && has_space_tag(ins_data.regime);
		new_ent.shared_set_flag = ins_data.shared_set_flag;
		new_ent.page            = ins_data.page;
		new_ent.address_space_tag = has_space_tag(ins_data.regime) ? ins_data.address_space_tag : '0;
		// with stage 2, vm-using regimes take their vm tag from the stream entry; otherwise zero is stored
		new_ent.virtual_machine_tag = uses_vm(ins_data.regime) ?
		                              vm_width(ins_data.stage2_vm_tag_field) : '0;
	end

	// ------------------------------------------------------------
	// tag store
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ENTRIES; i++)
				ent_r[i] <= '0;
		end else begin
			for (int i = 0; i < ENTRIES; i++)
				if (kill[i])
					ent_r[i].valid <= 1'b0;
			// an insert in the same cycle is newer than the invalidation
			if (ins_valid)
				ent_r[victim_r] <= new_ent;
		end
	end

	// round-robin replacement keeps the store free of any age tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			victim_r <= '0;
		else if (ins_valid)
			victim_r <= (victim_r == IW'(ENTRIES - 1)) ? '0 : victim_r + 1'b1;
	end

	// ------------------------------------------------------------
	// lookup
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_done_r  <= 1'b0;
			lk_hit_r   <= 1'b0;
			lk_index_r <= 8'h00;
		end else begin
			// the store is read as it stood before this edge's insert or kill
			lk_done_r <= lk_valid;
			if (lk_valid) begin
				lk_hit_r   <= 1'b0;
				lk_index_r <= 8'h00;
				for (int i = ENTRIES - 1; i >= 0; i--)
					if (lookup_hit(ent_r[i], lk_data)) begin
						lk_hit_r   <= 1'b1;
						lk_index_r <= 8'(i);
					end
			end
		end
	end

	assign lk_done  = lk_done_r;
	assign lk_hit   = lk_hit_r;
	assign lk_index = lk_index_r;

	// ------------------------------------------------------------
	// broadcast statistics
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_cnt_r <= 16'h0000;
			drop_cnt_r <= 16'h0000;
		end else if (bc_valid && bc_ready) begin
			// both counters wrap; software works with differences between reads
			if (bc_accept)
				done_cnt_r <= done_cnt_r + 16'h0001;
			else
				drop_cnt_r <= drop_cnt_r + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic        apb_go;
	logic        mapped;
	logic        wr_ctrl;
	logic [31:0] rd_val;
	logic [7:0]  occ;

	assign apb_go = psel && penable;

	// a write lands only at the edge that completes the access phase
	assign wr_ctrl = apb_go && pready && pwrite && paddr == `TBI_OFF_CTRL;

	// occupancy is a plain adder chain, cheap enough for the small default depth
	always_comb begin
		occ = 8'h00;
		for (int i = 0; i < ENTRIES; i++)
			occ = occ + {7'h00, ent_r[i].valid};
	end

	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`TBI_OFF_CAPS: begin
				rd_val[`TBI_CAPS_BCAST_BIT] = BCAST_SUPPORTED;
				rd_val[`TBI_CAPS_S2_BIT]    = STAGE2_PRESENT;
				rd_val[`TBI_CAPS_WIDE_BIT]  = STAGE2_PRESENT && WIDE_VM_TAG;
				rd_val[`TBI_CAPS_SEC_BIT]   = SECURE_PRESENT;
			end
			`TBI_OFF_CTRL:      rd_val = {28'h0000000, ctrl_r};
			`TBI_OFF_DONE_CNT:  rd_val = {16'h0000, done_cnt_r};
			`TBI_OFF_DROP_CNT:  rd_val = {16'h0000, drop_cnt_r};
			`TBI_OFF_OCCUPANCY: rd_val = {24'h000000, occ};
			default:            mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= `TBI_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_r <= pwdata[3:0];
	end

	// read data is captured in setup so the access phase answers at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (psel && !penable) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr_r <= !mapped;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r && psel && penable;

endmodule : tbi_tag_filter

// [tb/tbi_tag_filter_checker.sv]
// concurrent checks on the tag filter ports
// assumes binding onto the filter top with its capability parameters
`timescale 1ns/1ps

module tbi_tag_filter_checker #(
	parameter bit STAGE2_PRESENT  = 1'b1,
	parameter bit WIDE_VM_TAG     = 1'b1,
	parameter bit BCAST_SUPPORTED = 1'b1,
	parameter bit SECURE_PRESENT  = 1'b1
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        pready,
	input wire logic        lk_valid,
	input wire logic        lk_done,
	input wire logic        lk_hit,
	input wire logic [7:0]  lk_index,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic        bc_ready
);
	localparam logic [3:0] CAPS = {SECURE_PRESENT, STAGE2_PRESENT & WIDE_VM_TAG, STAGE2_PRESENT, BCAST_SUPPORTED};

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	caps_value_a: assert property (
		psel && !penable && !pwrite && paddr == 12'h000 ##1 penable |-> prdata[3:0] == CAPS)
		else $error("capability bits wrong");
	unmapped_error_a: assert property (
		psel && !penable && !pwrite && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}) ##1 penable
		|-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
	slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
	ctrl_back_a: assert property (
		psel && penable && pwrite && paddr == 12'h004 ##2 psel && !penable && !pwrite && paddr == 12'h004 ##1 penable
		|-> prdata[3:0] == $past(pwdata[3:0], 3)) else $error("control readback differs");
	lookup_answer_a: assert property (lk_valid |=> lk_done) else $error("lookup unanswered");
	done_cause_a: assert property (lk_done |-> $past(lk_valid)) else $error("stray lookup done");
	hit_hold_a: assert property (
		!lk_done |-> $stable(lk_hit) && $stable(lk_index)) else $error("lookup result moved");
	shared_path_a: assert property (bc_ready != cmd_valid) else $error("broadcast not held off");
	access_ready_a: assert property (psel && penable |-> pready) else $error("access phase stalled");
	cmd_taken_a: assert property (cmd_valid |-> cmd_ready) else $error("command refused");

endmodule : tbi_tag_filter_checker

// [tb/tbi_core_model.sv]
// behavioural processor core issuing broadcast invalidations
// assumes go is a one-cycle pulse with msg valid in the same cycle
`timescale 1ns/1ps

module tbi_core_model (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   go,
	input  wire tbi_pkg::tbi_bcast_type msg,
	input  wire logic                   bc_ready,
	output logic                        bc_valid,
	output tbi_pkg::tbi_bcast_type      bc_data,
	output logic                        busy
);
	import tbi_pkg::*;

	// ------------------------------------------------------------
	// message hold
	// ------------------------------------------------------------
	// after handover the data is inverted, never left looking valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bc_valid <= 1'b0;
			bc_data  <= '0;
			busy     <= 1'b0;
		end else if (go) begin
			bc_valid <= 1'b1;
			bc_data  <= msg;
			busy     <= 1'b1;
		end else if (bc_valid && bc_ready) begin
			bc_valid <= 1'b0;
			bc_data  <= ~bc_data;
			busy     <= 1'b0;
		end
	end

endmodule : tbi_core_model

// [tb/tbi_tag_filter_test.sv]
// self-checking bench for the tag filter
// assumes the package, filter, core model and checker are compiled first
`timescale 1ns/1ps

module tbi_tag_filter_test;
	import tbi_pkg::*;

	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata;
	logic           ins_valid, lk_valid, lk_done, lk_hit, cmd_valid, cmd_ready, bc_valid, bc_ready, bc_go, bc_busy;
	logic [7:0]     lk_index;
	tbi_insert_type ins_data;
	tbi_lookup_type lk_data;
	tbi_inval_type  cmd_data;
	tbi_bcast_type  bc_data, bc_msg;
	logic [32:0]    exp_q[$];
	logic [32:0]    seen;
	logic [15:0]    aa, va;
	logic [35:0]    pa;
	integer         seed = 20322;
	int             fails = 0;
	int             check_count = 0;

	tbi_tag_filter tbi_tag_filter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ins_valid, .ins_data, .lk_valid, .lk_data, .lk_done, .lk_hit, .lk_index, .cmd_valid, .cmd_data,
		.cmd_ready, .bc_valid, .bc_data, .bc_ready);
	tbi_core_model tbi_core_model_inst (.pclk, .presetn, .go(bc_go), .msg(bc_msg), .bc_ready, .bc_valid, .bc_data,
		.busy(bc_busy));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [32:0] got, input logic [32:0] want);
		check_count++;
		if (got !== want) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, want, got);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic note(input logic [32:0] v);
		exp_q.push_back(v);
	endtask : note

	// waits are bounded so a stuck handshake still reaches the report
	task automatic wait_on(ref logic sig, input logic level);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sig !== level && n < 50);
		if (sig !== level) begin
			fails++;
			stop_test();
		end
	endtask : wait_on

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		wait_on(pready, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [32:0] want);
		note(want);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic ins(input tbi_insert_type d);
		ins_data <= d;
		@(posedge pclk);
		ins_valid <= 1'b1;
		@(posedge pclk);
		ins_valid <= 1'b0;
	endtask : ins

	// want holds the expected slot index above the hit bit
	task automatic look(input tbi_lookup_type d, input logic [8:0] want);
		note({24'h0, want});
		lk_data <= d;
		@(posedge pclk);
		lk_valid <= 1'b1;
		@(posedge pclk);
		lk_valid <= 1'b0;
	endtask : look

	task automatic cmd(input tbi_inval_type d);
		cmd_data <= d;
		@(posedge pclk);
		cmd_valid <= 1'b1;
		@(posedge pclk);
		cmd_valid <= 1'b0;
	endtask : cmd

	task automatic bc(input tbi_bcast_type m);
		bc_msg <= m;
		@(posedge pclk);
		bc_go <= 1'b1;
		@(posedge pclk);
		bc_go <= 1'b0;
		wait_on(bc_busy, 1'b0);
	endtask : bc

	function automatic tbi_insert_type mk_in(tbi_regime_type r, logic g, logic s, logic [15:0] v);
		return '{r, 1'b0, g, s, aa, v, pa};
	endfunction : mk_in

	function automatic tbi_lookup_type mk_lk(tbi_regime_type r, logic s, logic [15:0] a, logic [15:0] v);
		return '{r, s, a, v, pa};
	endfunction : mk_lk

	function automatic tbi_bcast_type mk_bc(tbi_op_type o, tbi_regime_type r, logic [15:0] v, logic nh);
		return '{'{o, r, 1'b1, 1'b0, aa, v, pa}, 2'b01, 1'b0, nh};
	endfunction : mk_bc

	// ------------------------------------------------------------
	// result watcher
	// ------------------------------------------------------------
	// results are taken at the edge that closes each answer
	always @(posedge pclk) begin
		if (presetn && (lk_done === 1'b1 || (psel && penable && pready && !pwrite))) begin
			seen = lk_done ? {24'h0, lk_index, lk_hit} : {pslverr, prdata};
			check(lk_done ? "lookup hit" : "apb read", seen, exp_q.size() > 0 ? exp_q.pop_front() : ~seen);
		end
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, ins_valid, lk_valid, cmd_valid, bc_go, paddr, pwdata} = '0;
		{ins_data, lk_data, cmd_data, bc_msg} = '0;
		aa = 16'($random(seed));
		va = 16'($random(seed)) | 16'h1;
		pa = 36'({$random(seed), $random(seed)});
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, {1'b0, 32'hf});
		apb(1'b1, 12'h000, 32'h0);
		rd(12'h000, {1'b0, 32'hf});
		rd(12'h014, {1'b1, 32'h0});
		apb(1'b1, 12'h004, 32'h5);
		rd(12'h004, {1'b0, 32'h5});
		$display("test registers done");
		ins(mk_in(REG_NS_KERNEL, 1'b0, 1'b0, va));
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa, va), 9'h001);
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa, va ^ 16'h8000), 9'h000);
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa ^ 16'h1, va), 9'h000);
		bc(mk_bc(OP_BY_ADDRESS, REG_NS_KERNEL, va, 1'b0));
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa, va), 9'h001);
		apb(1'b1, 12'h004, 32'h0);
		bc(mk_bc(OP_BY_ADDRESS, REG_NS_KERNEL, va, 1'b0));
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa, va), 9'h001);
		apb(1'b1, 12'h004, 32'h4);
		bc(mk_bc(OP_BY_ADDRESS, REG_NS_KERNEL, va, 1'b0));
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa, va), 9'h000);
		$display("test broadcast filter done");
		ins(mk_in(REG_NS_KERNEL, 1'b0, 1'b1, va));
		bc(mk_bc(OP_BY_ADDRESS, REG_NS_KERNEL, va, 1'b0));
		bc(mk_bc(OP_BY_SPACE_TAG, REG_NS_KERNEL, va, 1'b0));
		look(mk_lk(REG_NS_KERNEL, 1'b1, aa, va), 9'h003);
		cmd('{OP_BY_ADDRESS, REG_NS_KERNEL, 1'b1, 1'b0, aa, va, pa});
		look(mk_lk(REG_NS_KERNEL, 1'b1, aa, va), 9'h000);
		ins(mk_in(REG_NS_KERNEL, 1'b0, 1'b0, 16'h0));
		bc(mk_bc(OP_BY_SPACE_TAG, REG_NS_KERNEL, 16'h5, 1'b1));
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa, 16'h0), 9'h000);
		$display("test set flag done");
		ins(mk_in(REG_HYP, 1'b0, 1'b1, 16'h0));
		bc(mk_bc(OP_BY_ADDRESS_ALL_TAGS, REG_HYP, 16'h0, 1'b0));
		look(mk_lk(REG_HYP, 1'b1, aa ^ 16'h3, 16'h0), 9'h007);
		bc(mk_bc(OP_HYP_INVALIDATE_ALL, REG_HYP, 16'h0, 1'b0));
		look(mk_lk(REG_HYP, 1'b1, aa, 16'h0), 9'h000);
		ins(mk_in(REG_NS_KERNEL, 1'b1, 1'b0, va));
		look(mk_lk(REG_NS_KERNEL, 1'b1, aa ^ 16'h1, va), 9'h000);
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa ^ 16'h1, va), 9'h009);
		rd(12'h008, {1'b0, 32'd6});
		rd(12'h00c, {1'b0, 32'd2});
		rd(12'h010, {1'b0, 32'd1});
		$display("test regimes and counts done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h004, {1'b0, 32'h0});
		rd(12'h010, {1'b0, 32'h0});
		look(mk_lk(REG_NS_KERNEL, 1'b0, aa ^ 16'h1, va), 9'h000);
		$display("test reset done");
		repeat (3) @(posedge pclk);
		stop_test();
	end

endmodule : tbi_tag_filter_test

bind tbi_tag_filter tbi_tag_filter_checker #(.STAGE2_PRESENT(STAGE2_PRESENT), .WIDE_VM_TAG(WIDE_VM_TAG),
	.BCAST_SUPPORTED(BCAST_SUPPORTED), .SECURE_PRESENT(SECURE_PRESENT)) tbi_tag_filter_checker_inst (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .lk_valid, .lk_done, .lk_hit,
	.lk_index, .cmd_valid, .cmd_ready, .bc_ready, .pready);
